// file: hbw_port.sv
// four-group host bus port with counted wait handshake
// Behaviour
// - stretch is counted in internal cycles of two core clock periods
// - strobe writes: ready low none, 5-7 imem, 9-29 data ram cycles
// - data ram overuse stretches wait up to 97 internal cycles
// - data-strobe chip select is OR of group select and lower strobe
// - data-strobe reads: ack low promptly for registers, after data for memory
// - data-strobe read ack: 6-7 imem, 9-33 data ram cycles
// - memory read data valid no later than acknowledge
// - ack may go from low straight to high impedance
// - handshake output driven only while its group is selected
// - four independent groups each with own select and handshake
// - data-strobe writes: ack low promptly for registers, late for memory
// - strobe reads: ready low none, 6-7 imem, 9-33 data ram cycles
`timescale 1ns/1ns
module hbw_port
#(
  parameter int FRAME_CYC = hbw_pkg::FRAME_CYC
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic data_strobe_style,
  input wire logic [3:0] group_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic lower_data_strobe_n,
  input wire logic read_not_write,
  input wire logic [7:0] host_addr,
  output logic [7:0] host_data_o,
  output logic host_data_oe,
  output logic [3:0] group_ready_o,
  output logic [3:0] group_ready_oe,
  output logic [3:0] group_transfer_ack_n_o,
  output logic [3:0] group_transfer_ack_n_oe,
  output logic [3:0] proc_req,
  output logic proc_write,
  input wire logic [3:0] proc_done,
  input wire logic [31:0] proc_rdata,
  input wire logic [7:0] reg_rdata
);

  // ************************************************************
  // internal processor cycle enable
  // ************************************************************
  logic [hbw_pkg::ACC_W-1:0] phase_reg, phase_next;
  logic proc_tick_reg, proc_tick_next;
  logic [hbw_pkg::ACC_W:0] phase_sum;

  always_comb
  begin
    phase_sum = {1'b0, phase_reg} + (hbw_pkg::ACC_W + 1)'(hbw_pkg::PROC_INC);
    proc_tick_next = 1'b0;
    phase_next = phase_sum[hbw_pkg::ACC_W-1:0];
    if (phase_sum >= (hbw_pkg::ACC_W + 1)'(hbw_pkg::SYS_CLK_KHZ))
    begin
      proc_tick_next = 1'b1;
      phase_next = (hbw_pkg::ACC_W)'(phase_sum
        - (hbw_pkg::ACC_W + 1)'(hbw_pkg::SYS_CLK_KHZ));
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_reg <= '0;
      proc_tick_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      proc_tick_reg <= proc_tick_next;
    end
  end

  // ************************************************************
  // access detection per group
  // ************************************************************
  hbw_pkg::hbw_access_t acc;
  logic [3:0] active, active_reg, start;
  logic [3:0] chip_sel_n;

  always_comb
  begin
    // the spare top code is served as data ram, never as a fourth kind
    if (host_addr[hbw_pkg::KIND_MSB])
      acc.kind = hbw_pkg::HBW_KIND_DRAM;
    else
      acc.kind = hbw_pkg::hbw_kind_t'(host_addr[hbw_pkg::KIND_MSB:
        hbw_pkg::KIND_LSB]);
    acc.write = data_strobe_style ? !read_not_write : !write_strobe_n;
    for (int g = 0; g < hbw_pkg::GROUPS; g++)
    begin
      chip_sel_n[g] = group_select_n[g] | lower_data_strobe_n;
      if (data_strobe_style)
        active[g] = !chip_sel_n[g];
      else
        active[g] = !group_select_n[g]
          && (!read_strobe_n || !write_strobe_n);
    end
    start = active & ~active_reg;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      active_reg <= 4'h0;
    else
      active_reg <= active;
  end

  // ************************************************************
  // data ram policing
  // ************************************************************
  logic [13:0] frame_reg, frame_next;
  logic [4:0] dram_cnt_reg [4];
  logic [4:0] dram_cnt_next [4];
  logic [6:0] gap_reg [4];
  logic [6:0] gap_next [4];
  logic [3:0] throttle;
  logic frame_end;

  always_comb
  begin
    frame_end = frame_reg == 14'(FRAME_CYC - 1);
    frame_next = frame_end ? 14'h0000 : frame_reg + 14'h0001;
    for (int g = 0; g < hbw_pkg::GROUPS; g++)
    begin
      // only data ram is policed; other kinds keep their own stretch
      throttle[g] = acc.kind == hbw_pkg::HBW_KIND_DRAM
        && ((dram_cnt_reg[g] >= hbw_pkg::FRAME_ACC_LIMIT)
        || (gap_reg[g] < hbw_pkg::GAP_LIMIT));
      dram_cnt_next[g] = frame_end ? 5'h00 : dram_cnt_reg[g];
      gap_next[g] = gap_reg[g];
      if (gap_reg[g] != hbw_pkg::GAP_LIMIT)
        gap_next[g] = gap_reg[g] + 7'h01;
      if (start[g] && acc.kind == hbw_pkg::HBW_KIND_DRAM)
      begin
        gap_next[g] = 7'h00;
        if (dram_cnt_next[g] != 5'h1f)
          dram_cnt_next[g] = dram_cnt_next[g] + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_reg <= 14'h0000;
      for (int g = 0; g < hbw_pkg::GROUPS; g++)
      begin
        dram_cnt_reg[g] <= 5'h00;
        gap_reg[g] <= hbw_pkg::GAP_LIMIT;
      end
    end
    else
    begin
      frame_reg <= frame_next;
      for (int g = 0; g < hbw_pkg::GROUPS; g++)
      begin
        dram_cnt_reg[g] <= dram_cnt_next[g];
        gap_reg[g] <= gap_next[g];
      end
    end
  end

  // ************************************************************
  // groups
  // ************************************************************
  hbw_pkg::hbw_status_t status [4];
  logic [7:0] grp_rdata [4];

  for (genvar g = 0; g < hbw_pkg::GROUPS; g++)
  begin : grp
    hbw_group u_group
    (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .proc_tick(proc_tick_reg),
      .start(start[g]),
      .active(active[g]),
      .acc(acc),
      .throttle(throttle[g]),
      .proc_done(proc_done[g]),
      .proc_rdata(proc_rdata[8*g +: 8]),
      .reg_rdata(reg_rdata),
      .status(status[g]),
      .proc_req(proc_req[g]),
      .rdata_reg(grp_rdata[g])
    );
  end

  assign proc_write = acc.write;

  // ************************************************************
  // pins
  // ************************************************************
  always_comb
  begin
    host_data_o = 8'h00;
    host_data_oe = 1'b0;
    for (int g = hbw_pkg::GROUPS - 1; g >= 0; g--)
    begin
      group_ready_oe[g] = !data_strobe_style && !group_select_n[g];
      group_ready_o[g] = !(status[g].waiting || (start[g]
        && acc.kind != hbw_pkg::HBW_KIND_REG));
      group_transfer_ack_n_oe[g] = data_strobe_style
        && !group_select_n[g];
      group_transfer_ack_n_o[g] = !status[g].complete;
      if (status[g].complete && status[g].is_read && active[g])
      begin
        host_data_o = grp_rdata[g];
        host_data_oe = 1'b1;
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  tick_spacing_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    proc_tick_reg |=> !proc_tick_reg [*3])
    else $error("internal cycle shorter than two core clocks");
  ack_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    group_select_n[0] |-> !group_transfer_ack_n_oe[0]
      && !group_ready_oe[0])
    else $error("handshake driven while group deselected");
  chip_select_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    data_strobe_style && (group_select_n[1] || lower_data_strobe_n)
      |-> !active[1])
    else $error("access seen without both select and strobe");
  ack_data_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    data_strobe_style && !group_transfer_ack_n_o[2] && status[2].is_read
      && active[2] |-> host_data_oe && host_data_o == grp_rdata[2])
    else $error("acknowledge ahead of read data");
  ready_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !data_strobe_style && start[3] && acc.kind == hbw_pkg::HBW_KIND_DRAM
      |-> !group_ready_o[3] ##1 !group_ready_o[3] [*8])
    else $error("data ram ready wait too short");
  reg_cov: cover property (@(posedge sys_clk) start[0]
    && acc.kind == hbw_pkg::HBW_KIND_REG);
  imem_cov: cover property (@(posedge sys_clk) start[1]
    && acc.kind == hbw_pkg::HBW_KIND_IMEM && acc.write);
  dram_cov: cover property (@(posedge sys_clk) start[2]
    && acc.kind == hbw_pkg::HBW_KIND_DRAM && data_strobe_style);

endmodule : hbw_port

// file: hbw_pkg.sv
// shared constants and carrier types of the host bus wait handshake port
package hbw_pkg;

  // ************************************************************
  // clocks and internal processor cycle
  // ************************************************************
  localparam int SYS_CLK_KHZ = 125000;
  localparam int CORE_CLK_KHZ = 58320;
  localparam int CORE_PER_PROC = 2;
  localparam int PROC_INC = CORE_CLK_KHZ / CORE_PER_PROC;
  localparam int ACC_W = 17;

  // ************************************************************
  // stretch limits in internal processor cycles
  // ************************************************************
  localparam logic [6:0] IMEM_WR_MIN = 7'h05;
  localparam logic [6:0] IMEM_WR_MAX = 7'h07;
  localparam logic [6:0] DRAM_WR_MIN = 7'h09;
  localparam logic [6:0] DRAM_WR_MAX = 7'h1d;
  localparam logic [6:0] IMEM_RD_MIN = 7'h06;
  localparam logic [6:0] IMEM_RD_MAX = 7'h07;
  localparam logic [6:0] DRAM_RD_MIN = 7'h09;
  localparam logic [6:0] DRAM_RD_MAX = 7'h21;
  localparam logic [6:0] THROTTLE_MAX = 7'h61;

  // ************************************************************
  // data ram access policing
  // ************************************************************
  localparam int FRAME_US = 125;
  localparam int FRAME_CYC = FRAME_US * SYS_CLK_KHZ / 1000;
  localparam int GAP_NS = 600;
  localparam int GAP_CYC = (GAP_NS * SYS_CLK_KHZ + 999999) / 1000000;
  localparam logic [6:0] GAP_LIMIT = 7'(GAP_CYC);
  localparam logic [4:0] FRAME_ACC_LIMIT = 5'h10;

  // ************************************************************
  // address decode and carriers
  // ************************************************************
  localparam int GROUPS = 4;
  localparam int KIND_MSB = 7;
  localparam int KIND_LSB = 6;

  typedef enum logic [1:0]
  {
    HBW_KIND_REG = 2'b00,
    HBW_KIND_IMEM = 2'b01,
    HBW_KIND_DRAM = 2'b10
  } hbw_kind_t;

  typedef struct packed
  {
    logic write;
    hbw_kind_t kind;
  } hbw_access_t;

  typedef struct packed
  {
    logic waiting;
    logic complete;
    logic is_read;
  } hbw_status_t;

endpackage : hbw_pkg

// file: hbw_group.sv
// one select group: stretch counter and handshake state
`timescale 1ns/1ns
module hbw_group
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic proc_tick,
  input wire logic start,
  input wire logic active,
  input wire hbw_pkg::hbw_access_t acc,
  input wire logic throttle,
  input wire logic proc_done,
  input wire logic [7:0] proc_rdata,
  input wire logic [7:0] reg_rdata,
  output hbw_pkg::hbw_status_t status,
  output logic proc_req,
  output logic [7:0] rdata_reg
);

  typedef enum logic [1:0]
  {
    HBW_ST_IDLE = 2'b00,
    HBW_ST_WAIT = 2'b01,
    HBW_ST_DONE = 2'b10
  } hbw_state_t;

  hbw_state_t state_reg, state_next;
  hbw_pkg::hbw_access_t acc_reg, acc_next;
  logic [6:0] cnt_reg, cnt_next;
  logic seen_reg, seen_next;
  logic thr_reg, thr_next;
  logic [7:0] rdata_next;
  logic [6:0] lo, hi;
  logic finish;

  // ************************************************************
  // limits of the access in progress
  // ************************************************************
  always_comb
  begin
    lo = hbw_pkg::DRAM_RD_MIN;
    hi = hbw_pkg::DRAM_RD_MAX;
    case ({acc_reg.write, acc_reg.kind})
      {1'b1, hbw_pkg::HBW_KIND_IMEM}:
      begin
        lo = hbw_pkg::IMEM_WR_MIN;
        hi = hbw_pkg::IMEM_WR_MAX;
      end
      {1'b1, hbw_pkg::HBW_KIND_DRAM}:
      begin
        lo = hbw_pkg::DRAM_WR_MIN;
        hi = hbw_pkg::DRAM_WR_MAX;
      end
      {1'b0, hbw_pkg::HBW_KIND_IMEM}:
      begin
        lo = hbw_pkg::IMEM_RD_MIN;
        hi = hbw_pkg::IMEM_RD_MAX;
      end
      default:
      begin
        lo = hbw_pkg::DRAM_RD_MIN;
        hi = hbw_pkg::DRAM_RD_MAX;
      end
    endcase
    // a policed access is held to the throttle length, done or not;
    // one tick past the least, as the first tick after start may be partial
    if (thr_reg)
      finish = cnt_reg >= hbw_pkg::THROTTLE_MAX;
    else
      finish = (cnt_reg > lo) && (seen_reg || cnt_reg >= hi);
  end

  // ************************************************************
  // state
  // ************************************************************
  always_comb
  begin
    state_next = state_reg;
    acc_next = acc_reg;
    cnt_next = cnt_reg;
    seen_next = seen_reg | proc_done;
    thr_next = thr_reg;
    rdata_next = rdata_reg;
    proc_req = 1'b0;
    case (state_reg)
      HBW_ST_IDLE:
      begin
        if (start)
        begin
          acc_next = acc;
          cnt_next = 7'h00;
          seen_next = 1'b0;
          thr_next = throttle;
          if (acc.kind == hbw_pkg::HBW_KIND_REG)
          begin
            state_next = HBW_ST_DONE;
            rdata_next = reg_rdata;
          end
          else
          begin
            state_next = HBW_ST_WAIT;
            proc_req = 1'b1;
          end
        end
      end
      HBW_ST_WAIT:
      begin
        if (proc_tick && cnt_reg != hbw_pkg::THROTTLE_MAX)
          cnt_next = cnt_reg + 7'h01;
        if (finish)
        begin
          state_next = HBW_ST_DONE;
          if (!acc_reg.write)
            rdata_next = proc_rdata;
        end
      end
      HBW_ST_DONE:
      begin
        if (!active)
          state_next = HBW_ST_IDLE;
      end
      default:
        state_next = HBW_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= HBW_ST_IDLE;
      acc_reg <= '0;
      cnt_reg <= 7'h00;
      seen_reg <= 1'b0;
      thr_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      acc_reg <= acc_next;
      cnt_reg <= cnt_next;
      seen_reg <= seen_next;
      thr_reg <= thr_next;
      rdata_reg <= rdata_next;
    end
  end

  assign status.waiting = state_reg == HBW_ST_WAIT;
  assign status.complete = state_reg == HBW_ST_DONE;
  assign status.is_read = !acc_reg.write;

  // ************************************************************
  // checks
  // ************************************************************
  reg_prompt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    start && acc.kind == hbw_pkg::HBW_KIND_REG |=> status.complete)
    else $error("register access not acknowledged next cycle");
  min_stretch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(status.complete) && $past(status.waiting) |->
      $past(cnt_reg) > $past(lo))
    else $error("memory access ended before its least stretch");
  max_stretch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    status.waiting && !thr_reg |-> cnt_reg <= hi)
    else $error("memory access stretched past its longest time");
  throttle_cap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    status.waiting |-> cnt_reg <= hbw_pkg::THROTTLE_MAX)
    else $error("throttled wait beyond its cap");
  read_data_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    status.waiting && finish && !acc_reg.write |=>
      rdata_reg == $past(proc_rdata))
    else $error("read data not in place at acknowledge");
  throttle_cov: cover property (@(posedge sys_clk) status.waiting && thr_reg
    && finish);

endmodule : hbw_group

// file: hbw_proc_model.sv
// behavioural embedded processor answering memory requests of the port
`timescale 1ns/1ns
module hbw_proc_model
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic prompt,
  input wire logic [3:0] proc_req,
  output logic [3:0] proc_done,
  output logic [31:0] proc_rdata
);
  int seed = 32'h1b7;
  int cnt [4];

  // ************************************************************
  // answer after a random delay, some beyond the stretch cap
  // ************************************************************
  // read data is set when the request is seen and stays put until the
  // next request of that group, so a capped completion still finds it
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      proc_done <= 4'h0;
      proc_rdata <= 32'h0;
      for (int g = 0; g < 4; g++) cnt[g] = -1;
    end
    else
    begin
      for (int g = 0; g < 4; g++)
      begin
        proc_done[g] <= cnt[g] == 0;
        if (cnt[g] >= 0) cnt[g] = cnt[g] - 1;
        if (proc_req[g])
        begin
          proc_rdata[8*g+:8] <= 8'($random(seed));
          cnt[g] = prompt ? 0 : $unsigned($random(seed)) % 160;
        end
      end
    end
  end
endmodule : hbw_proc_model

// file: host_bus_wait_handshake_tb_top.sv
// self-checking bench of the host bus wait handshake port
`timescale 1ns/1ns
module host_bus_wait_handshake_tb_top;
  logic sys_clk;
  logic rst_n;
  logic data_strobe_style;
  logic prompt;
  logic [3:0] group_select_n;
  logic read_strobe_n, write_strobe_n, lower_data_strobe_n, read_not_write;
  logic [7:0] host_addr, reg_rdata, host_data_o;
  logic host_data_oe, proc_write;
  logic [3:0] group_ready_o, group_ready_oe, proc_req, proc_done;
  logic [3:0] group_transfer_ack_n_o, group_transfer_ack_n_oe;
  logic [31:0] proc_rdata;
  int seed = 32'h2fea;
  int n_fail = 0;
  int checks_done = 0;

  hbw_port #(.FRAME_CYC(200)) u_dut
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .data_strobe_style(data_strobe_style),
    .group_select_n(group_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n),
    .lower_data_strobe_n(lower_data_strobe_n),
    .read_not_write(read_not_write), .host_addr(host_addr),
    .host_data_o(host_data_o), .host_data_oe(host_data_oe),
    .group_ready_o(group_ready_o), .group_ready_oe(group_ready_oe),
    .group_transfer_ack_n_o(group_transfer_ack_n_o),
    .group_transfer_ack_n_oe(group_transfer_ack_n_oe),
    .proc_req(proc_req), .proc_write(proc_write), .proc_done(proc_done),
    .proc_rdata(proc_rdata), .reg_rdata(reg_rdata)
  );

  hbw_proc_model u_proc
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .prompt(prompt), .proc_req(proc_req),
    .proc_done(proc_done), .proc_rdata(proc_rdata)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // checking helpers
  // ************************************************************
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, seen);
      n_fail++;
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // system clock cycles spanned by n internal processor cycles
  function automatic int cyc(int n);
    cyc = n * hbw_pkg::CORE_PER_PROC * hbw_pkg::SYS_CLK_KHZ
      / hbw_pkg::CORE_CLK_KHZ;
  endfunction : cyc

  function automatic int lim(hbw_pkg::hbw_kind_t k, logic rd, logic hi);
    case (k)
      hbw_pkg::HBW_KIND_IMEM: lim = hi ? 7 : (rd ? 6 : 5);
      hbw_pkg::HBW_KIND_DRAM: lim = hi ? (rd ? 33 : 29) : 9;
      default: lim = 0;
    endcase
  endfunction : lim

  // ************************************************************
  // one host access with handshake, then release and idle gap
  // ************************************************************
  task automatic access(int g, hbw_pkg::hbw_kind_t k, logic rd, logic thr,
    int gap);
    logic [7:0] exp_d;
    logic is_reg;
    int n;
    int lo;
    int hi;
    is_reg = (k == hbw_pkg::HBW_KIND_REG);
    lo = thr ? cyc(96) : (is_reg ? 0 : cyc(lim(k, rd, 0)));
    hi = thr ? cyc(97) + 3 : cyc(lim(k, rd, 1)) + 3;
    @(posedge sys_clk);
    // data ram is also reached through the spare top kind code
    host_addr <= {k, 6'($random(seed))}
      | {1'b0, k == hbw_pkg::HBW_KIND_DRAM && $random(seed) % 2 == 0, 6'h00};
    read_not_write <= rd;
    reg_rdata <= 8'($random(seed));
    group_select_n[g] <= 1'b0;
    if (data_strobe_style) lower_data_strobe_n <= 1'b0;
    else if (rd) read_strobe_n <= 1'b0;
    else write_strobe_n <= 1'b0;
    #1;
    exp_d = reg_rdata;
    check("ready oe", group_ready_oe,
      4'(1 << g) & {4{!data_strobe_style}});
    check("ack oe", group_transfer_ack_n_oe,
      4'(1 << g) & {4{data_strobe_style}});
    check("proc req", proc_req, is_reg ? 4'h0 : 4'(1 << g));
    check("proc write", proc_write, !rd);
    n = 0;
    while ((data_strobe_style ? group_transfer_ack_n_o[g]
      : !group_ready_o[g]) === 1'b1 && n < 700)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 700)
    begin
      n_fail++;
      conclude();
    end
    if (is_reg) check("reg wait", n, data_strobe_style);
    else check("mem wait", n >= lo && n <= hi, 1'b1);
    // an unpoliced prompt data ram access fits in 80 system clock cycles
    if (prompt && !thr && k == hbw_pkg::HBW_KIND_DRAM)
      check("wait within 640 ns", n * 8 <= 640, 1'b1);
    if (rd)
    begin
      if (is_reg && !data_strobe_style)
      begin
        @(posedge sys_clk);
        #1;
      end
      if (!is_reg) exp_d = proc_rdata[8*g+:8];
      check("data oe", host_data_oe, 1'b1);
      check("read data", host_data_o, exp_d);
    end
    else check("data oe", host_data_oe, 1'b0);
    @(posedge sys_clk);
    group_select_n <= 4'hf;
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    lower_data_strobe_n <= 1'b1;
    #1;
    check("ready oe off", group_ready_oe, 4'h0);
    check("ack oe off", group_transfer_ack_n_oe, 4'h0);
    repeat (gap) @(posedge sys_clk);
  endtask : access

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    rst_n = 1'b0;
    data_strobe_style = 1'b0;
    prompt = 1'b0;
    group_select_n = 4'hf;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    lower_data_strobe_n = 1'b1;
    read_not_write = 1'b1;
    host_addr = 8'h00;
    reg_rdata = 8'h00;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int st = 0; st < 2; st++)
    begin
      @(posedge sys_clk);
      data_strobe_style <= st[0];
      prompt <= 1'b0;
      for (int g = 0; g < 4; g++)
        for (int k = 0; k < 3; k++)
          for (int rd = 0; rd < 2; rd++)
            access(g, hbw_pkg::hbw_kind_t'(k), rd[0], 1'b0, k == 2 ? 100 : 2);
      repeat (12)
        access($unsigned($random(seed)) % 4,
          hbw_pkg::hbw_kind_t'($unsigned($random(seed)) % 3),
          1'($random(seed)), 1'b0, 100);
      // a prompt data ram access, then a second one far too soon after it
      prompt <= 1'b1;
      access(1, hbw_pkg::HBW_KIND_DRAM, 1'b0, 1'b0, 2);
      access(1, hbw_pkg::HBW_KIND_DRAM, 1'b1, 1'b1, 100);
    end
    // select without the lower strobe, and strobe without select: idle
    for (int g = 0; g < 4; g++)
    begin
      @(posedge sys_clk);
      group_select_n[g] <= 1'b0;
      repeat (3)
      begin
        @(posedge sys_clk);
        #1;
        check("no req", proc_req, 4'h0);
        check("ack idle", group_transfer_ack_n_o[g], 1'b1);
      end
      @(posedge sys_clk);
      group_select_n[g] <= 1'b1;
      lower_data_strobe_n <= 1'b0;
      @(posedge sys_clk);
      #1;
      check("no req", proc_req, 4'h0);
      @(posedge sys_clk);
      lower_data_strobe_n <= 1'b1;
    end
    conclude();
  end
endmodule : host_bus_wait_handshake_tb_top
